// file: logic/difr_map.svh
/*
 Register offsets, reset values and field widths of the
 ideality / averaging / identification register slice.
 Assumes an 8-bit register address and 8-bit data path.
*/
`ifndef DIFR_MAP_SVH
`define DIFR_MAP_SVH

// Register offsets
`define DIFR_ADDR_IDEALITY 8'h27
`define DIFR_ADDR_AVERAGE  8'h40
`define DIFR_ADDR_PART_ID  8'hfd
`define DIFR_ADDR_MAKER_ID 8'hfe
`define DIFR_ADDR_DIE_REV  8'hff

// Reset values
`define DIFR_RST_IDEALITY  6'h12
`define DIFR_RST_AVERAGE   2'h0

// Field widths
`define DIFR_IDEAL_W       6
`define DIFR_AVG_W         2

// Valid ideality code span
`define DIFR_IDEAL_MIN     6'h08
`define DIFR_IDEAL_MAX     6'h37

`endif

// file: logic/difr_pkg.sv
/*
 Types shared by the register slice.
 Assumes difr_map.svh is compiled alongside.
*/
`default_nettype none

package difr_pkg;

    // Averaging strength seen by the external channel filter
    typedef enum logic [1:0]
    {
        DIFR_AVG_OFF,
        DIFR_AVG_LVL1,
        DIFR_AVG_LVL2
    } difr_avg_t;

endpackage

`default_nettype wire

// file: logic/difr_avg_decode.sv
/*
 Decoder from the two-bit averaging field to the filter level.
 Assumes a combinational use on the same clock as the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module difr_avg_decode
(
    input  wire logic [1:0]        field,
    output difr_pkg::difr_avg_t    level
);

    // 01 and 10 share the first level
    always_comb
    begin
        unique case (field)
            2'h0:    level = difr_pkg::DIFR_AVG_OFF;
            2'h1:    level = difr_pkg::DIFR_AVG_LVL1;
            2'h2:    level = difr_pkg::DIFR_AVG_LVL1;
            2'h3:    level = difr_pkg::DIFR_AVG_LVL2;
        endcase
    end

endmodule

`default_nettype wire

// file: logic/difr_regs.sv
/*
 Ideality, averaging and identification registers of a
 two-channel temperature monitor.
 Assumes a serial-port engine on the same clock that presents
 one-cycle write and read strobes with an 8-bit register address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "difr_map.svh"

module difr_regs
#(
    parameter logic [7:0] PART_ID  = 8'ha1, // Arbitrary value
    parameter logic [7:0] MAKER_ID = 8'hb2, // Arbitrary value
    parameter logic [7:0] DIE_REV  = 8'h01  // Arbitrary value
)
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    output logic [5:0]             ideality_code,
    output logic                   ideality_valid,
    output difr_pkg::difr_avg_t    filter_level
);

    ////////////////////////////////////////////////////////////////
    // Storage
    logic [5:0]           ideal_r;   // Ideality code
    logic [1:0]           avg_r;     // Averaging field
    difr_pkg::difr_avg_t  level_nxt; // Decoded filter level

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Read mux; unused bits and holes read as zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                          input logic [5:0] ic,
                                          input logic [1:0] av);
        unique case (a)
            `DIFR_ADDR_IDEALITY: rd_mux = {2'h0, ic};
            `DIFR_ADDR_AVERAGE:  rd_mux = {6'h00, av};
            `DIFR_ADDR_PART_ID:  rd_mux = PART_ID;
            `DIFR_ADDR_MAKER_ID: rd_mux = MAKER_ID;
            `DIFR_ADDR_DIE_REV:  rd_mux = DIE_REV;
            default:             rd_mux = 8'h00;
        endcase
    endfunction

    // Code lies in the defined factor table
    function automatic logic code_ok(input logic [5:0] c);
        code_ok = (c >= `DIFR_IDEAL_MIN) && (c <= `DIFR_IDEAL_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Ideality register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ideal_r <= `DIFR_RST_IDEALITY;
        end
        else if (reg_wr && reg_addr == `DIFR_ADDR_IDEALITY)
        begin
            // Upper two bits dropped, kept zero
            ideal_r <= reg_wdata[5:0];
        end
    end

    // Averaging register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            avg_r <= `DIFR_RST_AVERAGE;
        end
        else if (reg_wr && reg_addr == `DIFR_ADDR_AVERAGE)
        begin
            avg_r <= reg_wdata[1:0];
        end
    end
    // Identifier writes decode to nothing: accepted, no effect.

    ////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'h0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= rd_mux(reg_addr, ideal_r, avg_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs toward conversion engine and filter
    difr_avg_decode u_difr_avg_decode
    (
        .field (avg_r),
        .level (level_nxt)
    );

    // Registered copies so every output leaves a flip-flop
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ideality_code  <= `DIFR_RST_IDEALITY;
            ideality_valid <= 1'h1;
            filter_level   <= difr_pkg::DIFR_AVG_OFF;
        end
        else
        begin
            // Engine looks factor up; out-of-table codes flagged
            ideality_code  <= ideal_r;
            ideality_valid <= code_ok(ideal_r);
            filter_level   <= level_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    chk_ideal_write: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr == `DIFR_ADDR_IDEALITY |=> ##1
        ideality_code == $past(reg_wdata[5:0], 2))
        else $error("ideality code not written");

    chk_ideal_range: assert property (@(posedge clock) disable iff (reset)
        ideality_valid == (ideality_code >= `DIFR_IDEAL_MIN &&
                           ideality_code <= `DIFR_IDEAL_MAX))
        else $error("ideality range flag wrong");

    chk_avg_level: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr == `DIFR_ADDR_AVERAGE && reg_wdata[1:0] == 2'h3
        |=> ##1 filter_level == difr_pkg::DIFR_AVG_LVL2)
        else $error("averaging level two not selected");

    chk_avg_off: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr == `DIFR_ADDR_AVERAGE && reg_wdata[1:0] == 2'h0
        |=> ##1 filter_level == difr_pkg::DIFR_AVG_OFF)
        else $error("averaging not disabled");

    chk_avg_read: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `DIFR_ADDR_AVERAGE |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
        else $error("averaging upper bits not zero");

    chk_part_id: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `DIFR_ADDR_PART_ID |=> reg_rdata == PART_ID)
        else $error("part identifier wrong");

    chk_maker_id: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `DIFR_ADDR_MAKER_ID |=> reg_rdata == MAKER_ID)
        else $error("maker identifier wrong");

    chk_die_rev: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `DIFR_ADDR_DIE_REV |=> reg_rdata == DIE_REV)
        else $error("die revision wrong");

    chk_ideal_upper: assert property (@(posedge clock) disable iff (reset)
        reg_rd && reg_addr == `DIFR_ADDR_IDEALITY |=> reg_rdata[7:6] == 2'h0)
        else $error("ideality upper bits not zero");

    // Middle code pair must share the first level, not fall to off
    chk_avg_lvl1: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr == `DIFR_ADDR_AVERAGE &&
        (reg_wdata[1:0] == 2'h1 || reg_wdata[1:0] == 2'h2)
        |=> ##1 filter_level == difr_pkg::DIFR_AVG_LVL1)
        else $error("averaging level one not selected");

    // Defaults on every release of reset, mid-run ones included
    chk_reset_outs: assert property (@(posedge clock)
        $fell(reset) |-> ideality_code == `DIFR_RST_IDEALITY && ideality_valid &&
        filter_level == difr_pkg::DIFR_AVG_OFF && !reg_rvalid)
        else $error("outputs not at defaults after reset");

    chk_reset_regs: assert property (@(posedge clock)
        $fell(reset) |-> avg_r == `DIFR_RST_AVERAGE && ideal_r == `DIFR_RST_IDEALITY)
        else $error("registers not at defaults after reset");

    // Read strobe answered by exactly one valid pulse
    chk_rvalid_pulse: assert property (@(posedge clock) disable iff (reset)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");

    chk_rvalid_quiet: assert property (@(posedge clock) disable iff (reset)
        !reg_rd |=> !reg_rvalid)
        else $error("valid without a read");

    // Identifier writes must leave the writable registers alone
    chk_id_write_ign: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr >= `DIFR_ADDR_PART_ID |=> $stable(ideal_r) && $stable(avg_r))
        else $error("identifier write disturbed a register");

    // Registers only move on a write to their own address
    chk_ideal_hold: assert property (@(posedge clock) disable iff (reset)
        !(reg_wr && reg_addr == `DIFR_ADDR_IDEALITY) |=> $stable(ideal_r))
        else $error("ideality code changed without a write");

    chk_avg_hold: assert property (@(posedge clock) disable iff (reset)
        !(reg_wr && reg_addr == `DIFR_ADDR_AVERAGE) |=> $stable(avg_r))
        else $error("averaging field changed without a write");

endmodule

`default_nettype wire

// file: test/difr_host_model.sv
/*
 Host model: register reads and writes by one-cycle strobes.
 Assumes the bench shares its clock and calls the tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module difr_host_model
(
    input  wire logic       clock,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic       reg_rvalid,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////
    // Write: lines scrambled once released, so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    end
    endtask
    // Read: data and valid taken at the edge that samples the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        d = reg_rdata;
        v = reg_rvalid;
    end
    endtask
endmodule
`default_nettype wire

// file: test/tb_difr_regs.sv
/*
 Bench for the register slice: reset defaults, each register, ids.
 Assumes difr_regs and difr_host_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_difr_regs;
    // Arbitrary identifier values
    localparam logic [7:0] PART_V = 8'h5a;
    localparam logic [7:0] MAKER_V = 8'h3c;
    localparam logic [7:0] REV_V = 8'h07;
    logic                clock = 1'b0;
    logic                reset = 1'b1;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata;
    logic                reg_wr, reg_rd, reg_rvalid, ideality_valid;
    logic [5:0]          ideality_code;
    difr_pkg::difr_avg_t filter_level;
    int                  err_count = 0;
    int                  n_compared = 0;
    int                  cycles = 0;
    difr_regs #(.PART_ID(PART_V), .MAKER_ID(MAKER_V), .DIE_REV(REV_V)) u_difr_regs
    (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
     .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
     .reg_rvalid(reg_rvalid), .ideality_code(ideality_code),
     .ideality_valid(ideality_valid), .filter_level(filter_level));
    difr_host_model u_difr_host_model
    (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
     .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata));
    ////////////////////////////////////////
    // 10 MHz clock
    always #50 clock = ~clock;
    // Hang guard, far above the under one hundred cycles needed
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict;
    begin
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Read back with valid pulse check
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
    begin
        u_difr_host_model.rd(a, d, v);
        cmp(d, exp);
        cmp({7'h0, v}, 8'h01);
    end
    endtask
    task automatic t_reset;
    begin
        cmp({2'h0, ideality_code}, 8'h12);
        cmp({7'h0, ideality_valid}, 8'h01);
        cmp({6'h0, filter_level}, 8'h00);
        chk_rd(8'h27, 8'h12);
        chk_rd(8'h40, 8'h00);
    end
    endtask
    // Span edges of the code, top bits dropped, node setting last
    task automatic t_ideality;
        logic [7:0] c[6] = '{8'hff, 8'h07, 8'h08, 8'h37, 8'h38, 8'h15};
        logic [5:0] k;
    begin
        foreach (c[i])
        begin
            u_difr_host_model.wr(8'h27, c[i]);
            k = c[i][5:0];
            chk_rd(8'h27, {2'h0, k});
            cmp({2'h0, ideality_code}, {2'h0, k});
            cmp({7'h0, ideality_valid}, {7'h0, k >= 6'h08 && k <= 6'h37});
        end
    end
    endtask
    // Every averaging code, upper bits set to prove they drop
    task automatic t_filter;
        difr_pkg::difr_avg_t lv[4] = '{difr_pkg::DIFR_AVG_OFF, difr_pkg::DIFR_AVG_LVL1,
                                        difr_pkg::DIFR_AVG_LVL1, difr_pkg::DIFR_AVG_LVL2};
    begin
        for (int f = 0; f < 4; f++)
        begin
            u_difr_host_model.wr(8'h40, {6'h3f, f[1:0]});
            chk_rd(8'h40, {6'h00, f[1:0]});
            cmp({6'h0, filter_level}, {6'h0, lv[f]});
        end
    end
    endtask
    // Mid-run reset puts changed registers back to defaults
    task automatic t_rerun;
    begin
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset();
    end
    endtask
    // Identifiers survive writes; unmapped place reads zero
    task automatic t_ids;
        logic [7:0] ad[3] = '{8'hfd, 8'hfe, 8'hff};
        logic [7:0] ex[3] = '{PART_V, MAKER_V, REV_V};
    begin
        foreach (ad[i])
        begin
            u_difr_host_model.wr(ad[i], ~ex[i]);
            chk_rd(ad[i], ex[i]);
        end
        chk_rd(8'h10, 8'h00);
        u_difr_host_model.wr(8'h27, 8'h12);
        chk_rd(8'h27, 8'h12);
    end
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset();
        t_ideality();
        t_filter();
        t_rerun();
        t_ids();
        give_verdict();
    end
endmodule
`default_nettype wire
